// ---- hw/wake_filter.sv ----
`timescale 1ns/1ps
`include "wake_pin_regs.svh"

module wake_filter
   import wake_pin_pkg::*;
#(
   parameter int unsigned FILTER_CYCLES = `WK_FILTER_CYCLES
)
(
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic active, // filter runs only while powered
   input wire logic pin_in, // raw wake input
   output logic level, // level: filtered while active, raw pin while inactive
   output wake_edge_t edges // one-cycle accepted edges
);

   localparam int unsigned CW = $clog2(FILTER_CYCLES + 1);

   typedef struct packed {
      logic level;
      logic [CW-1:0] cnt;
      wake_edge_t edges;
   } filt_state_t;

   filt_state_t st_ff;
   filt_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.edges = '0;
      if (!active || pin_in == st_ff.level)
      begin
         nxt_st.cnt = '0;
      end
      else if (st_ff.cnt == CW'(FILTER_CYCLES - 1))
      begin
         // new level held for the whole filter time
         nxt_st.cnt = '0;
         nxt_st.level = pin_in;
         nxt_st.edges.rise = pin_in;
         nxt_st.edges.fall = !pin_in;
      end
      else
      begin
         nxt_st.cnt = st_ff.cnt + CW'(1);
      end
      if (!active)
      begin
         nxt_st.level = pin_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign level = st_ff.level;
   assign edges = st_ff.edges;

endmodule

// ---- hw/wake_irq.sv ----
`timescale 1ns/1ps
`include "wake_pin_regs.svh"

module wake_irq
#(
   parameter int unsigned N = 4
)
(
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic [N-1:0] set, // event pulses
   input wire logic [N-1:0] clr, // software clear pulses
   input wire logic [N-1:0] en_wdata, // enable write data
   input wire logic en_we, // enable write strobe
   output logic [N-1:0] stat, // sticky status
   output logic [N-1:0] en, // enable register
   output logic irq // level interrupt
);

   typedef struct packed {
      logic [N-1:0] stat;
      logic [N-1:0] en;
      logic irq;
   } irq_state_t;

   irq_state_t st_ff;
   irq_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_st = st_ff;
      for (int i = 0; i < N; i++)
      begin
         // set wins over a clear in the same cycle
         nxt_st.stat[i] = set[i] | (st_ff.stat[i] & !clr[i]); // [RULE12]
      end
      if (en_we)
      begin
         nxt_st.en = en_wdata;
      end
      nxt_st.irq = |(nxt_st.stat & nxt_st.en); // [RULE9]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff.stat <= '0;
         st_ff.en <= N'(`WK_IRQ_EN_RESET);
         st_ff.irq <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign stat = st_ff.stat;
   assign en = st_ff.en;
   assign irq = st_ff.irq;

endmodule

// ---- hw/wake_pin_monitor.sv ----
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "wake_pin_regs.svh"

// Function
// (RULE1) both rising and falling wake_input transitions count as wake events
// (RULE2) a new level must persist past the filter time, else it is rejected
// (RULE3) software enable bit wake_pin_enable turns wake capability on or off
// (RULE4) below undervoltage_off_level pin is high impedance and events ignored
// (RULE5) in normal, stop and flash modes wake_level_bit shows the pin level
// (RULE6) enabled and in sleep, a filtered edge wakes the chip
// (RULE7) in fail-safe, a filtered edge always requests restart
// (RULE8) enabled in normal, stop or flash, edges set rise/fall flags and interrupt
// (RULE9) rising and falling interrupts are masked independently
// (RULE10) a flag pending at sleep entry causes immediate wake after entering sleep
// (RULE11) software should clear both wake flags before commanding sleep
// (RULE12) each wake flag stays set until software clears it
module wake_pin_monitor
   import wake_pin_pkg::*;
#(
   parameter int unsigned FILTER_CYCLES = `WK_FILTER_CYCLES
)
(
   input wire logic pclk, // apb clock, 40 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic wake_input_i, // wake pin level
   output logic wake_input_o, // pin drive value, never driven high
   output logic wake_input_oe_n, // pin enable, low drives; always high
   output logic wake_req, // pulse: wake from sleep
   output logic restart_req, // pulse: fail-safe to restart
   output logic irq // level interrupt
);

   localparam int unsigned NIRQ = 4;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic pin_en;
      sbc_mode_t mode;
      logic uv_off;
      logic wake_req;
      logic restart_req;
      logic sleep_seen;
      logic oe_n;
   } top_state_t;

   top_state_t st_ff;
   top_state_t nxt_st;

   wake_edge_t filt_edges;
   logic [NIRQ-1:0] irq_set;
   logic [NIRQ-1:0] irq_clr;
   logic [NIRQ-1:0] irq_stat;
   logic [NIRQ-1:0] irq_en;
   logic irq_en_we;
   logic irq_out;
   logic wr_acc;
   logic rd_acc;
   logic any_edge;
   logic mode_report;
   logic filt_active;

   ////////////////////////////////////////////////////////////////////////
   // pin filter, halted in the off state
   assign filt_active = !st_ff.uv_off && st_ff.mode != mode_off; // [RULE4]

   wake_filter #(
      .FILTER_CYCLES(FILTER_CYCLES)
   ) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .active(filt_active),
      .pin_in(wake_input_i),
      .level(),
      .edges(filt_edges) // [RULE2]
   );

   assign any_edge = filt_edges.rise | filt_edges.fall; // [RULE1]
   assign mode_report = st_ff.mode == mode_normal || st_ff.mode == mode_stop ||
                        st_ff.mode == mode_sw_flash;

   ////////////////////////////////////////////////////////////////////////
   // apb decode: one wait state, pready is registered the cycle after the access is taken
   assign wr_acc = psel && penable && pwrite && !st_ff.pready;
   assign rd_acc = psel && penable && !pwrite && !st_ff.pready;

   always_comb
   begin
      irq_set = '0;
      irq_set[`WK_IRQ_RISE] = st_ff.pin_en && mode_report && filt_edges.rise; // [RULE8]
      irq_set[`WK_IRQ_FALL] = st_ff.pin_en && mode_report && filt_edges.fall; // [RULE8]
      irq_set[`WK_IRQ_SLEEP_WAKE] = nxt_st.wake_req;
      irq_set[`WK_IRQ_RESTART] = nxt_st.restart_req;
   end

   assign irq_clr = (wr_acc && paddr == `WK_ADDR_IRQ_CLR) ? pwdata[NIRQ-1:0] : '0; // [RULE12]
   assign irq_en_we = wr_acc && paddr == `WK_ADDR_IRQ_EN;

   wake_irq #(
      .N(NIRQ)
   ) u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .set(irq_set),
      .clr(irq_clr),
      .en_wdata(pwdata[NIRQ-1:0]),
      .en_we(irq_en_we),
      .stat(irq_stat),
      .en(irq_en),
      .irq(irq_out)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;
      nxt_st.wake_req = 1'b0;
      nxt_st.restart_req = 1'b0;
      nxt_st.oe_n = 1'b1; // [RULE4]
      nxt_st.sleep_seen = st_ff.mode == mode_sleep;

      if (filt_active)
      begin
         case (st_ff.mode)
            mode_sleep:
            begin
               // pending flags re-wake right after entering sleep
               if ((st_ff.pin_en && any_edge) || // [RULE6]
                   (!st_ff.sleep_seen &&
                    (irq_stat[`WK_IRQ_RISE] || irq_stat[`WK_IRQ_FALL]))) // [RULE10]
               begin
                  nxt_st.wake_req = 1'b1;
               end
            end
            mode_fail_safe:
            begin
               nxt_st.restart_req = any_edge; // [RULE7]
            end
            default:
            begin
               nxt_st.wake_req = 1'b0;
            end
         endcase
      end

      if (psel && penable && !st_ff.pready)
      begin
         nxt_st.pready = 1'b1;
         nxt_st.prdata = '0;
         case (paddr)
            `WK_ADDR_CTRL:
            begin
               if (pwrite)
               begin
                  nxt_st.pin_en = pwdata[`WK_CTRL_PIN_EN]; // [RULE3]
                  nxt_st.mode = sbc_mode_t'(pwdata[`WK_CTRL_MODE_MSB:`WK_CTRL_MODE_LSB]);
                  nxt_st.uv_off = pwdata[`WK_CTRL_UV_OFF];
               end
               nxt_st.prdata[`WK_CTRL_PIN_EN] = st_ff.pin_en;
               nxt_st.prdata[`WK_CTRL_MODE_MSB:`WK_CTRL_MODE_LSB] = st_ff.mode;
               nxt_st.prdata[`WK_CTRL_UV_OFF] = st_ff.uv_off;
            end
            `WK_ADDR_STATUS:
            begin
               nxt_st.prdata[`WK_STAT_LEVEL] = mode_report && filt_active &&
                                               wake_input_i; // [RULE5]
               nxt_st.prdata[`WK_STAT_MODE_MSB:`WK_STAT_MODE_LSB] = st_ff.mode;
            end
            `WK_ADDR_IRQ_STAT:
            begin
               nxt_st.prdata[NIRQ-1:0] = irq_stat;
            end
            `WK_ADDR_IRQ_EN:
            begin
               nxt_st.prdata[NIRQ-1:0] = irq_en;
            end
            `WK_ADDR_IRQ_CLR:
            begin
               nxt_st.prdata = '0;
            end
            default:
            begin
               nxt_st.pslverr = 1'b1;
            end
         endcase
         if (!pwrite && paddr == `WK_ADDR_CTRL)
         begin
            nxt_st.pin_en = st_ff.pin_en;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff.prdata <= '0;
         st_ff.pready <= 1'b0;
         st_ff.pslverr <= 1'b0;
         st_ff.pin_en <= 1'(`WK_CTRL_RESET >> `WK_CTRL_PIN_EN);
         st_ff.mode <= mode_init;
         st_ff.uv_off <= 1'b0;
         st_ff.wake_req <= 1'b0;
         st_ff.restart_req <= 1'b0;
         st_ff.sleep_seen <= 1'b0;
         st_ff.oe_n <= 1'b1;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign wake_input_o = 1'b0;
   assign wake_input_oe_n = st_ff.oe_n;
   assign wake_req = st_ff.wake_req;
   assign restart_req = st_ff.restart_req;
   assign irq = irq_out;

endmodule

// ---- hw/wake_pin_pkg.sv ----
package wake_pin_pkg;

   typedef enum logic [2:0] {
      mode_off,
      mode_init,
      mode_normal,
      mode_stop,
      mode_sleep,
      mode_restart,
      mode_fail_safe,
      mode_sw_flash
   } sbc_mode_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   typedef struct packed {
      logic rise;
      logic fall;
   } wake_edge_t;

endpackage

// ---- hw/wake_pin_regs.svh ----
`ifndef WAKE_PIN_REGS_SVH
`define WAKE_PIN_REGS_SVH

// register byte addresses
`define WK_ADDR_CTRL 12'h000
`define WK_ADDR_STATUS 12'h004
`define WK_ADDR_IRQ_STAT 12'h008
`define WK_ADDR_IRQ_EN 12'h00c
`define WK_ADDR_IRQ_CLR 12'h010

// control register fields
`define WK_CTRL_PIN_EN 0
`define WK_CTRL_MODE_LSB 4
`define WK_CTRL_MODE_MSB 6
`define WK_CTRL_UV_OFF 8

// status register fields
`define WK_STAT_LEVEL 0
`define WK_STAT_MODE_LSB 4
`define WK_STAT_MODE_MSB 6

// interrupt bit positions (status, enable, clear share the layout)
`define WK_IRQ_RISE 0
`define WK_IRQ_FALL 1
`define WK_IRQ_SLEEP_WAKE 2
`define WK_IRQ_RESTART 3

// reset values
`define WK_CTRL_RESET 32'h0000_0000
`define WK_IRQ_EN_RESET 4'h3

// filter time in nanoseconds and clock period in nanoseconds
`define WK_FILTER_NS 10000
`define WK_CLK_PERIOD_NS 25
`define WK_FILTER_CYCLES ((`WK_FILTER_NS + `WK_CLK_PERIOD_NS - 1) / `WK_CLK_PERIOD_NS)

`endif

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench
   import wake_pin_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lvl = 0, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, pin_i, pin_o, pin_oe_n, wake_req, restart_req, irq;
   int bad_count = 0, cmp_count = 0, cyc = 0, wk_n = 0, rs_n = 0, seed = 84, len, i;
   wake_pin_monitor #(.FILTER_CYCLES(8)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .wake_input_i(pin_i),
      .wake_input_o(pin_o), .wake_input_oe_n(pin_oe_n), .wake_req, .restart_req, .irq);
   wake_switch sw_u (.oe_n(pin_oe_n), .o(pin_o), .lvl, .pin(pin_i));
   always #12.5 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cyc++;
      if (wake_req === 1'b1)
         wk_n++;
      if (restart_req === 1'b1)
         rs_n++;
      if (cyc > 20000)
      begin
         bad_count++;
         wrap_up;
      end
   end
   ////////////////////////////////////////
   task wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q & m, x);
   endtask
   task pin(input logic v, input int n);
      @(posedge pclk);
      lvl <= v;
      repeat (n) @(posedge pclk);
   endtask
   task clr;
      apb(1'b1, 12'h010, 32'hf);
   endtask
   function automatic logic [31:0] exp_flags(input int n);
      return (n > 8) ? 32'h3 : 32'h0;
   endfunction
   ////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h00c, 32'hf, 32'h3);
      rd(12'h008, 32'hf, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk(e, 1'b1);
      $display("test registers done");
      apb(1'b1, 12'h000, 32'h21);
      pin(1'b1, 16);
      rd(12'h004, 32'h1, 32'h1);
      rd(12'h008, 32'h3, 32'h1);
      chk(irq, 1'b1);
      pin(1'b0, 40);
      rd(12'h008, 32'h3, 32'h3);
      clr;
      rd(12'h008, 32'h3, 32'h0);
      chk(irq, 1'b0);
      apb(1'b1, 12'h00c, 32'h2);
      pin(1'b1, 16);
      rd(12'h008, 32'h3, 32'h1);
      chk(irq, 1'b0);
      pin(1'b0, 16);
      chk(irq, 1'b1);
      clr;
      apb(1'b1, 12'h00c, 32'h3);
      $display("test flags done");
      for (i = 0; i < 6; i++)
      begin
         len = ($random(seed) & 1) ? 2 + ($random(seed) & 3) : 12 + ($random(seed) & 7);
         pin(1'b1, len);
         pin(1'b0, 16);
         rd(12'h008, 32'h3, exp_flags(len));
         clr;
      end
      $display("test filter done");
      apb(1'b1, 12'h000, 32'h20);
      pin(1'b1, 16);
      pin(1'b0, 16);
      rd(12'h008, 32'h3, 32'h0);
      apb(1'b1, 12'h000, 32'h30);
      pin(1'b1, 16);
      rd(12'h004, 32'h1, 32'h1);
      apb(1'b1, 12'h000, 32'h70);
      rd(12'h004, 32'h1, 32'h1);
      clr;
      apb(1'b1, 12'h000, 32'h41);
      pin(1'b0, 16);
      chk(wk_n, 1);
      apb(1'b1, 12'h000, 32'h21);
      pin(1'b1, 16);
      apb(1'b1, 12'h000, 32'h41);
      repeat (4) @(posedge pclk);
      chk(wk_n, 2);
      clr;
      $display("test sleep done");
      apb(1'b1, 12'h000, 32'h60);
      pin(1'b0, 16);
      chk(rs_n, 1);
      apb(1'b1, 12'h000, 32'h160);
      pin(1'b1, 16);
      pin(1'b0, 16);
      chk(rs_n, 1);
      chk(pin_oe_n, 1'b1);
      $display("test fail-safe done");
      wrap_up;
   end
endmodule

// ---- tb/wake_pin_properties.sv ----
`timescale 1ns/1ps
module wake_pin_properties
#(
   parameter int unsigned FILTER_CYCLES = 8
)
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pwrite, // apb
   input wire logic [11:0] paddr, // apb
   input wire logic [31:0] prdata, // apb
   input wire logic pready, // apb
   input wire logic pslverr, // apb
   input wire logic wake_input_i, // pin
   input wire logic wake_input_o, // pin
   input wire logic wake_input_oe_n, // pin
   input wire logic wake_req, // wake
   input wire logic restart_req, // restart
   input wire logic irq // interrupt
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] stable_ff;
   logic last_ff;
   // cycles since the pin last changed
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stable_ff <= 8'h00;
         last_ff <= 1'b0;
      end
      else
      begin
         last_ff <= wake_input_i;
         if (wake_input_i != last_ff)
            stable_ff <= 8'h00;
         else if (stable_ff != 8'hff)
            stable_ff <= stable_ff + 8'h01;
      end
   end
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   a_ready_access: assert property (pready |-> psel && penable) else $error("pready idle");
   a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_unmapped_err: assert property (pready && paddr > 12'h010 |-> pslverr)
      else $error("unmapped accepted");
   a_clr_reads_zero: assert property (pready && !pwrite && paddr == 12'h010 |-> prdata == 32'h0)
      else $error("clear reads nonzero");
   a_pin_undriven: assert property (wake_input_oe_n && !wake_input_o)
      else $error("pin driven");
   a_wake_pulse: assert property (wake_req |=> !wake_req) else $error("wake_req long");
   a_restart_filter: assert property (restart_req |-> stable_ff >= FILTER_CYCLES / 2)
      else $error("restart unfiltered");
   a_irq_quiet: assert property ($rose(presetn) |-> !irq) else $error("irq after reset");
   cover property (restart_req);
   cover property (wake_req);
   cover property (irq);
   cover property (pslverr);
endmodule
bind wake_pin_monitor wake_pin_properties #(.FILTER_CYCLES(FILTER_CYCLES)) chk_u (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .wake_input_i,
   .wake_input_o, .wake_input_oe_n, .wake_req, .restart_req, .irq);

// ---- tb/wake_switch.sv ----
`timescale 1ns/1ps
module wake_switch
(
   input wire logic oe_n, // device enable, low drives
   input wire logic o, // device drive value
   input wire logic lvl, // switch level
   output logic pin // line level
);
   // the switch owns the line unless the device drives it
   assign pin = oe_n ? lvl : o;
endmodule
